// ### strap_cfg_pkg.sv
package strap_cfg_pkg;
    localparam int          CLK_MHZ          = 125;
    localparam int          RESET_HOLD_MS    = 100;
    localparam int          RESET_HOLD_CYC   = RESET_HOLD_MS * CLK_MHZ * 1000;
    localparam int          REF_MAX_STEP_MHZ = 333;
    localparam logic [3:0]  NOMINAL_HALF     = 4'h3;
    localparam logic [3:0]  REF_HALF         = 4'h4;
    localparam logic [3:0]  FRAME_HALF       = 4'h8;
    localparam logic [3:0]  PRE_PG_CYC       = 4'hF;
    localparam logic [3:0]  STRAP_HOLD_CYC   = 4'h8;
    // Strap field positions on the interrupt pins.
    localparam int          STRAP_FRAME_BIT  = 5;
    localparam int          STRAP_FWD_BIT    = 4;
    localparam int          STRAP_DIV_MSB    = 3;
    // Divisor code decode and reset values.
    localparam logic [3:0]  DIV_CODE_EIGHT   = 4'h0;
    localparam logic [4:0]  DIV_EIGHT        = 5'h08;
    localparam logic [4:0]  DIV_MIN          = 5'h03;
    localparam logic [3:0]  DIV_CODE_RST     = 4'h0;
    localparam logic [5:0]  IRQ_RST          = 6'h00;

    typedef enum logic [1:0] {
        settle_wait_state = 2'b00,
        capture_state     = 2'b01,
        wait_nominal      = 2'b10,
        run_state         = 2'b11
    } dev_state_type;

    typedef enum logic [1:0] {
        host_off     = 2'b00,
        host_settle  = 2'b01,
        host_hold    = 2'b10,
        host_run     = 2'b11
    } host_state_type;
endpackage : strap_cfg_pkg

// ### strap_link_if.sv
`timescale 1ns/10ps
// Board-level pins between the clocking front end and the system logic.
interface strap_link_if;
    logic       power_good_in;
    logic       pll_bypass_sel;
    logic       ref_clk_in;
    logic [5:0] irq_pins;
    logic       frame_clk_in;
    logic       fwd_clk_reset_in;
    logic       sys_reset_n;
    logic       divided_feedback_clk;

    modport dev (
        input  power_good_in,
        input  pll_bypass_sel,
        input  ref_clk_in,
        input  irq_pins,
        input  frame_clk_in,
        input  fwd_clk_reset_in,
        input  sys_reset_n,
        output divided_feedback_clk
    );

    modport host (
        output power_good_in,
        output pll_bypass_sel,
        output ref_clk_in,
        output irq_pins,
        output frame_clk_in,
        output fwd_clk_reset_in,
        output sys_reset_n,
        input  divided_feedback_clk
    );
endinterface : strap_link_if

// ### strap_config_clock_ratio.sv
`timescale 1ns/10ps
module strap_config_clock_ratio
    import strap_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    strap_link_if.dev       link,
    output logic            core_global_clock,
    output logic            charge_pump_en,
    output logic            frame_copy_sel,
    output logic            fwd_int_sel,
    output logic [4:0]      sys_clock_divisor,
    output logic            internal_frame_clk,
    output logic            fwd_clk_reset_int,
    output logic [5:0]      irq_req,
    output logic            sys_activity_en,
    output logic [1:0]      init_state
);

    // Translates the strapped code into the divide ratio.
    function automatic logic [4:0] decode_div(input logic [3:0] code);
        logic [4:0] d;
        d = {1'b0, code};
        if (code == DIV_CODE_EIGHT) begin
            d = DIV_EIGHT;
        end else if (code[3]) begin
            d = {1'b0, code} + 5'h01;
        end else if ({1'b0, code} < DIV_MIN) begin
            d = DIV_MIN;
        end
        return d;
    endfunction : decode_div

    typedef struct packed {
        logic          pg_s1;
        logic          pg_s2;
        logic          pg_d;
        logic [5:0]    irq_s1;
        logic [5:0]    irq_s2;
        logic          ref_s1;
        logic          ref_s2;
        logic          ref_d;
        logic          frm_s1;
        logic          frm_s2;
        logic          frm_d;
        logic          fwr_s1;
        logic          fwr_s2;
        logic          byp_s1;
        logic          byp_s2;
        logic          rstn_s1;
        logic          rstn_s2;
        dev_state_type state;
        logic          frame_copy;
        logic          fwd_int;
        logic [3:0]    div_code;
        logic          pump_en;
        logic [3:0]    vco_cnt;
        logic          core_clk;
        logic [4:0]    div_cnt;
        logic          fb_clk;
        logic          int_frame;
        logic          int_frame_d;
        logic          fwd_rst;
        logic [5:0]    irq_out;
        logic          active;
    } dev_type;

    dev_type    st_r;
    dev_type    st_nxt;
    logic [4:0] decode_div_r;

    // Next-state logic for the whole front end.
    always_comb begin
        logic       pg_rise;
        logic       ref_rise;
        logic       core_tick;
        logic       frm_rise;
        logic       ifrm_rise;
        logic [4:0] div;
        pg_rise   = 1'b0;
        ref_rise  = 1'b0;
        core_tick = 1'b0;
        frm_rise  = 1'b0;
        ifrm_rise = 1'b0;
        div       = decode_div(st_r.div_code);
        st_nxt    = st_r;

        // Every pin from the board passes two flip-flops first.
        st_nxt.pg_s1   = link.power_good_in;
        st_nxt.pg_s2   = st_r.pg_s1;
        st_nxt.pg_d    = st_r.pg_s2;
        st_nxt.irq_s1  = link.irq_pins;
        st_nxt.irq_s2  = st_r.irq_s1;
        st_nxt.ref_s1  = link.ref_clk_in;
        st_nxt.ref_s2  = st_r.ref_s1;
        st_nxt.ref_d   = st_r.ref_s2;
        st_nxt.frm_s1  = link.frame_clk_in;
        st_nxt.frm_s2  = st_r.frm_s1;
        st_nxt.frm_d   = st_r.frm_s2;
        st_nxt.fwr_s1  = link.fwd_clk_reset_in;
        st_nxt.fwr_s2  = st_r.fwr_s1;
        st_nxt.byp_s1  = link.pll_bypass_sel;
        st_nxt.byp_s2  = st_r.byp_s1;
        st_nxt.rstn_s1 = link.sys_reset_n;
        st_nxt.rstn_s2 = st_r.rstn_s1;

        pg_rise  = st_r.pg_s2 & ~st_r.pg_d;
        ref_rise = st_r.ref_s2 & ~st_r.ref_d;

        // Reset sequencing; straps are taken once per power-good rise.
        case (st_r.state)
            settle_wait_state: begin
                st_nxt.pump_en = 1'b0;
                if (pg_rise) begin
                    st_nxt.state      = capture_state;
                    st_nxt.frame_copy = st_r.irq_s2[STRAP_FRAME_BIT];
                    st_nxt.fwd_int    = st_r.irq_s2[STRAP_FWD_BIT];
                    st_nxt.div_code   = st_r.irq_s2[STRAP_DIV_MSB:0];
                    st_nxt.pump_en    = 1'b1;
                end
            end
            capture_state: begin
                st_nxt.state = wait_nominal;
            end
            wait_nominal: begin
                if (st_r.rstn_s2) begin
                    st_nxt.state = run_state;
                end
            end
            run_state: begin
                if (!st_r.rstn_s2) begin
                    st_nxt.state = wait_nominal;
                end
            end
            default: begin
                st_nxt.state = settle_wait_state;
            end
        endcase
        // Losing power-good drops back to initialization at once.
        if (!st_r.pg_s2) begin
            st_nxt.state   = settle_wait_state;
            st_nxt.pump_en = 1'b0;
        end

        // Core clock source: reference copy in bypass, else the modelled VCO.
        if (!st_r.byp_s2) begin
            st_nxt.core_clk = st_r.ref_s2;
            st_nxt.vco_cnt  = 4'h0;
        end else if (st_r.state == settle_wait_state) begin
            // The oscillator idles at a slow nominal rate without power-good.
            if (st_r.vco_cnt == NOMINAL_HALF) begin
                st_nxt.vco_cnt  = 4'h0;
                st_nxt.core_clk = ~st_r.core_clk;
            end else begin
                st_nxt.vco_cnt = st_r.vco_cnt + 4'h1;
            end
        end else begin
            st_nxt.vco_cnt  = 4'h0;
            st_nxt.core_clk = ~st_r.core_clk;
        end
        core_tick = st_nxt.core_clk & ~st_r.core_clk;

        // Feedback divider counts core edges in both modes.
        // Only the second synchroniser stage is read, so a metastable first stage never leaks.
        if (st_r.byp_s2 && st_r.pump_en && ref_rise) begin
            st_nxt.div_cnt = 5'h00;
        end else if (core_tick) begin
            if (st_r.div_cnt >= div - 5'h01) begin
                st_nxt.div_cnt = 5'h00;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 5'h01;
            end
        end
        st_nxt.fb_clk = (st_nxt.div_cnt < {1'b0, div[4:1]});

        // Internal frame clock from the external pin or a feedback copy.
        st_nxt.int_frame   = st_r.frame_copy ? st_r.fb_clk : st_r.frm_s2;
        st_nxt.int_frame_d = st_r.int_frame;
        frm_rise  = st_r.frm_s2 & ~st_r.frm_d;
        ifrm_rise = st_r.int_frame & ~st_r.int_frame_d;
        if (st_r.fwd_int ? ifrm_rise : frm_rise) begin
            st_nxt.fwd_rst = st_r.fwr_s2;
        end

        // The pins mean interrupts only once initialization is over.
        st_nxt.active  = (st_r.state == run_state);
        st_nxt.irq_out = (st_r.state == run_state) ? st_r.irq_s2 : IRQ_RST;
    end

    // State register; straps survive a reset-pin pulse by design.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r            <= '0;
            st_r.state      <= settle_wait_state;
            st_r.div_code   <= DIV_CODE_RST;
            st_r.irq_out    <= IRQ_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.divided_feedback_clk = st_r.fb_clk;
    assign core_global_clock         = st_r.core_clk;
    assign charge_pump_en            = st_r.pump_en;
    assign frame_copy_sel            = st_r.frame_copy;
    assign fwd_int_sel               = st_r.fwd_int;
    assign sys_clock_divisor         = decode_div_r;
    assign internal_frame_clk        = st_r.int_frame;
    assign fwd_clk_reset_int         = st_r.fwd_rst;
    assign irq_req                   = st_r.irq_out;
    assign sys_activity_en           = st_r.active;
    assign init_state                = st_r.state;

    // Decoded divisor kept in its own flop so the output is registered.
    always_ff @(posedge clk) begin
        if (rst) begin
            decode_div_r <= DIV_EIGHT;
        end else begin
            decode_div_r <= decode_div(st_nxt.div_code);
        end
    end

endmodule : strap_config_clock_ratio

// ### strap_board_host.sv
`timescale 1ns/10ps
module strap_board_host
    import strap_cfg_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst,
    strap_link_if.host      link,
    input  wire logic       power_on,
    input  wire logic [5:0] strap_cfg,
    input  wire logic       bypass_req,
    input  wire logic [5:0] irq_src,
    output logic            power_good,
    output logic            board_ready
);

    typedef struct packed {
        host_state_type state;
        logic [31:0]    hold_cnt;
        logic [3:0]     step_cnt;
        logic           pg;
        logic           rstn;
        logic [5:0]     pins;
        logic           straps_out;
        logic [3:0]     ref_cnt;
        logic           ref_clk;
        logic [3:0]     frm_cnt;
        logic           frm_clk;
        logic           fwd_rst;
        logic           bypass;
        logic           ready;
    } host_type;

    host_type st_r;
    host_type st_nxt;

    // Board sequencing, reference and frame clock generation.
    always_comb begin
        st_nxt = st_r;
        // Fixed reference rate, so it never steps by more than the allowed jump.
        if (st_r.ref_cnt == REF_HALF - 4'h1) begin
            st_nxt.ref_cnt = 4'h0;
            st_nxt.ref_clk = ~st_r.ref_clk;
        end else begin
            st_nxt.ref_cnt = st_r.ref_cnt + 4'h1;
        end
        // Frame clock runs slower than the reference.
        if (st_r.frm_cnt == FRAME_HALF - 4'h1) begin
            st_nxt.frm_cnt = 4'h0;
            st_nxt.frm_clk = ~st_r.frm_clk;
        end else begin
            st_nxt.frm_cnt = st_r.frm_cnt + 4'h1;
        end
        st_nxt.bypass = bypass_req;
        // Straps stand on the pins from before power-good until held long enough.
        st_nxt.pins = st_r.straps_out ? strap_cfg : irq_src;

        case (st_r.state)
            host_off: begin
                st_nxt.pg         = 1'b0;
                st_nxt.rstn       = 1'b0;
                st_nxt.fwd_rst    = 1'b1;
                st_nxt.straps_out = 1'b1;
                st_nxt.step_cnt   = 4'h0;
                if (power_on) begin
                    st_nxt.state = host_settle;
                end
            end
            host_settle: begin
                st_nxt.step_cnt = st_r.step_cnt + 4'h1;
                if (st_r.step_cnt == PRE_PG_CYC) begin
                    st_nxt.state    = host_hold;
                    st_nxt.pg       = 1'b1;
                    st_nxt.step_cnt = 4'h0;
                    st_nxt.hold_cnt = 32'h0;
                end
            end
            host_hold: begin
                if (st_r.step_cnt != STRAP_HOLD_CYC) begin
                    st_nxt.step_cnt = st_r.step_cnt + 4'h1;
                end else begin
                    st_nxt.straps_out = 1'b0;
                end
                st_nxt.hold_cnt = st_r.hold_cnt + 32'h1;
                if (st_r.hold_cnt >= HOLD_CYCLES - 1 && !st_r.straps_out) begin
                    st_nxt.state   = host_run;
                    st_nxt.rstn    = 1'b1;
                    st_nxt.fwd_rst = 1'b0;
                end
            end
            host_run: begin
                st_nxt.ready = 1'b1;
            end
            default: begin
                st_nxt.state = host_off;
            end
        endcase
        if (!power_on) begin
            st_nxt.state = host_off;
            st_nxt.pg    = 1'b0;
            st_nxt.rstn  = 1'b0;
            st_nxt.ready = 1'b0;
        end
    end

    // Reset holds the board in its power-off condition.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r            <= '0;
            st_r.state      <= host_off;
            st_r.straps_out <= 1'b1;
            st_r.fwd_rst    <= 1'b1;
            st_r.bypass     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.power_good_in    = st_r.pg;
    assign link.pll_bypass_sel   = st_r.bypass;
    assign link.ref_clk_in       = st_r.ref_clk;
    assign link.irq_pins         = st_r.pins;
    assign link.frame_clk_in     = st_r.frm_clk;
    assign link.fwd_clk_reset_in = st_r.fwd_rst;
    assign link.sys_reset_n      = st_r.rstn;
    assign power_good            = st_r.pg;
    assign board_ready           = st_r.ready;

endmodule : strap_board_host

// ### strap_config_checker.sv
`timescale 1ns/10ps
// Watches the strap link and the loader outputs for capture, hold and clock rules.
module strap_config_checker
    import strap_cfg_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       power_good_in,
    input wire logic       pll_bypass_sel,
    input wire logic       ref_clk_in,
    input wire logic [5:0] irq_pins,
    input wire logic       divided_feedback_clk,
    input wire logic       core_global_clock,
    input wire logic       charge_pump_en,
    input wire logic       frame_copy_sel,
    input wire logic       fwd_int_sel,
    input wire logic [4:0] sys_clock_divisor,
    input wire logic [5:0] irq_req,
    input wire logic       sys_activity_en,
    input wire logic [1:0] init_state
);
    logic       fb_q;
    logic       fb_rise;
    logic       pump_q;
    logic [4:0] div_q;
    logic [1:0] seen;
    int         gap;

    // Own decode of the strap pins into frame bit, sampling bit and divisor.
    function automatic logic [6:0] strap_of(input logic [5:0] p);
        logic [4:0] d;
        if (p[3:0] == 4'h0) d = 5'h08;
        else if (p[3:0] < 4'h3) d = 5'h03;
        else if (p[3:0] < 4'h8) d = {1'b0, p[3:0]};
        else d = {1'b0, p[3:0]} + 5'h01;
        return {p[5], p[4], d};
    endfunction : strap_of

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Clock gap between feedback rises; the first intervals after a divisor or capture
    // change are skipped, since the divide counter may restart mid-count there.
    assign fb_rise = divided_feedback_clk & ~fb_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            fb_q   <= 1'b0;
            pump_q <= 1'b0;
            div_q  <= 5'h08;
            seen   <= 2'h0;
            gap    <= 0;
        end else begin
            fb_q   <= divided_feedback_clk;
            pump_q <= charge_pump_en;
            div_q  <= sys_clock_divisor;
            gap    <= fb_rise ? 0 : gap + 1;
            if (pll_bypass_sel || div_q != sys_clock_divisor || pump_q != charge_pump_en)
                seen <= 2'h0;
            else if (fb_rise && seen != 2'h3)
                seen <= seen + 2'h1;
        end
    end

    a_pump_on_power: assert property ($rose(power_good_in) |-> ##3 charge_pump_en)
        else $error("charge pump not enabled after power good");
    a_strap_capture: assert property ($rose(charge_pump_en) |->
        {frame_copy_sel, fwd_int_sel, sys_clock_divisor} == strap_of($past(irq_pins, 3)))
        else $error("straps differ from pins at capture");
    a_straps_held: assert property ((charge_pump_en && $past(charge_pump_en)) |->
        $stable(sys_clock_divisor) && $stable(frame_copy_sel) && $stable(fwd_int_sel))
        else $error("latched straps changed while pump on");
    a_quiet_in_init: assert property ((init_state != run_state &&
        $past(init_state) != run_state) |-> !sys_activity_en && irq_req == 6'h00)
        else $error("system activity outside run");
    a_irq_follow: assert property ((sys_activity_en && $past(sys_activity_en, 3) &&
        $stable(irq_pins) && irq_pins == $past(irq_pins, 2) && irq_pins == $past(irq_pins, 3))
        |-> irq_req == irq_pins)
        else $error("interrupt requests do not follow pins");
    a_settle_hold: assert property ((!power_good_in) [*5] |->
        init_state == settle_wait_state && !charge_pump_en)
        else $error("not settled while power good low");
    a_bypass_copy: assert property ((!pll_bypass_sel) [*5] |->
        core_global_clock == $past(ref_clk_in, 3))
        else $error("core clock is not reference copy in bypass");
    a_pll_fast: assert property ((pll_bypass_sel && charge_pump_en && power_good_in) [*4] |->
        core_global_clock != $past(core_global_clock))
        else $error("core clock not at full rate with pll");
    a_bypass_ratio: assert property ((fb_rise && seen == 2'h3) |->
        gap == 2 * int'(REF_HALF) * int'(sys_clock_divisor) - 1)
        else $error("feedback period is not divisor times reference");
endmodule : strap_config_checker

// ### strap_config_clock_ratio_tb.sv
`timescale 1ns/10ps
// Joins the loader to the board host and checks captures and clock rates at the ports.
module strap_config_clock_ratio_tb
    import strap_cfg_pkg::*;
;
    logic       clk;
    logic       rst;
    logic       power_on;
    logic       bypass_req;
    logic [5:0] strap_cfg;
    logic [5:0] irq_src;
    logic       power_good;
    logic       board_ready;
    logic       core_global_clock;
    logic       charge_pump_en;
    logic       frame_copy_sel;
    logic       fwd_int_sel;
    logic [4:0] sys_clock_divisor;
    logic       internal_frame_clk;
    logic       fwd_clk_reset_int;
    logic [5:0] irq_req;
    logic       sys_activity_en;
    logic [1:0] init_state;
    int         errors;
    int         check_count;
    int         per;

    strap_link_if strap_link_if_i ();

    strap_config_clock_ratio strap_config_clock_ratio_i (.clk(clk), .rst(rst),
        .link(strap_link_if_i.dev), .core_global_clock(core_global_clock),
        .charge_pump_en(charge_pump_en), .frame_copy_sel(frame_copy_sel),
        .fwd_int_sel(fwd_int_sel), .sys_clock_divisor(sys_clock_divisor),
        .internal_frame_clk(internal_frame_clk), .fwd_clk_reset_int(fwd_clk_reset_int),
        .irq_req(irq_req), .sys_activity_en(sys_activity_en), .init_state(init_state));

    // A short hold keeps the run small; the real part waits far longer for the loop.
    strap_board_host #(.HOLD_CYCLES(32)) strap_board_host_i (.clk(clk), .rst(rst),
        .link(strap_link_if_i.host), .power_on(power_on), .strap_cfg(strap_cfg),
        .bypass_req(bypass_req), .irq_src(irq_src), .power_good(power_good),
        .board_ready(board_ready));

    strap_config_checker strap_config_checker_i (.clk(clk), .rst(rst),
        .power_good_in(strap_link_if_i.power_good_in),
        .pll_bypass_sel(strap_link_if_i.pll_bypass_sel),
        .ref_clk_in(strap_link_if_i.ref_clk_in), .irq_pins(strap_link_if_i.irq_pins),
        .divided_feedback_clk(strap_link_if_i.divided_feedback_clk),
        .core_global_clock(core_global_clock), .charge_pump_en(charge_pump_en),
        .frame_copy_sel(frame_copy_sel), .fwd_int_sel(fwd_int_sel),
        .sys_clock_divisor(sys_clock_divisor), .irq_req(irq_req),
        .sys_activity_en(sys_activity_en), .init_state(init_state));

    // The clock runs at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected divisor for a strap code; codes one and two read as three.
    function automatic logic [4:0] dec(input logic [3:0] c);
        if (c == 4'h0) return 5'h08;
        if (c < 4'h3) return 5'h03;
        return (c < 4'h8) ? {1'b0, c} : {1'b0, c} + 5'h01;
    endfunction : dec

    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wrap_up;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task fail_out;
        errors++;
        $display("ERROR %0t: wait ran out", $time);
        wrap_up();
    endtask : fail_out

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Drops power, sets the straps while the host is off, then powers up until run.
    task power_cycle(input logic [5:0] cfg, input logic byp);
        int n;
        cyc(1);
        power_on <= 1'b0;
        cyc(8);
        strap_cfg  <= cfg;
        bypass_req <= byp;
        cyc(4);
        power_on <= 1'b1;
        n = 0;
        while (board_ready !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 400) fail_out();
        end
        cyc(8);
        @(negedge clk);
    endtask : power_cycle

    // Period in clocks of feedback (0), core (1) or internal frame clock (2).
    task meas(input int which, output int p);
        int   n;
        int   rises;
        logic v;
        logic q;
        n = 0;
        rises = 0;
        p = 0;
        q = 1'b1;
        while (rises < 2) begin
            @(negedge clk);
            v = (which == 0) ? strap_link_if_i.divided_feedback_clk :
                (which == 1) ? core_global_clock : internal_frame_clk;
            if (v === 1'b1 && q === 1'b0) rises++;
            if (rises == 1) p++;
            q = v;
            n++;
            if (n > 600) fail_out();
        end
    endtask : meas

    task t_reset;
        @(negedge clk);
        check(16'(sys_clock_divisor), 16'h0008);
        check(16'({charge_pump_en, sys_activity_en}), 16'h0000);
        check(16'(init_state), 16'(settle_wait_state));
        meas(1, per);
        check(16'(per), 16'(2 * (int'(NOMINAL_HALF) + 1)));
    endtask : t_reset

    // Every divisor code in bypass: decode, reference rate on core, feedback ratio.
    task t_divisors;
        for (int c = 0; c < 16; c++) begin
            power_cycle({2'b00, c[3:0]}, 1'b0);
            check(16'(sys_clock_divisor), 16'(dec(c[3:0])));
            check(16'(charge_pump_en), 16'h0001);
            meas(1, per);
            check(16'(per), 16'(2 * int'(REF_HALF)));
            meas(0, per);
            check(16'(per), 16'(2 * int'(REF_HALF) * int'(dec(c[3:0]))));
        end
    endtask : t_divisors

    // All four frame and sampling strap settings, divisor four in bypass.
    task t_frame;
        for (int m = 0; m < 4; m++) begin
            power_cycle({m[1:0], 4'h4}, 1'b0);
            check(16'({frame_copy_sel, fwd_int_sel}), 16'(m[1:0]));
            meas(2, per);
            check(16'(per), m[1] ? 16'(8 * int'(REF_HALF)) : 16'(2 * int'(FRAME_HALF)));
            check(16'(fwd_clk_reset_int), 16'h0000);
        end
    endtask : t_frame

    // Pins carry interrupts in run; the latched straps must not follow them.
    task t_irq;
        logic [5:0] v [3];
        v = '{6'h2A, 6'h15, 6'h3F};
        for (int i = 0; i < 3; i++) begin
            cyc(1);
            irq_src <= v[i];
            cyc(6);
            @(negedge clk);
            check(16'(irq_req), 16'(v[i]));
            check(16'({frame_copy_sel, fwd_int_sel, sys_clock_divisor}), 16'h0064);
        end
    endtask : t_irq

    // With the pll in use the core runs every clock and feedback matches the reference.
    task t_pll;
        power_cycle(6'h04, 1'b1);
        meas(1, per);
        check(16'(per), 16'h0002);
        meas(0, per);
        check(16'(per), 16'(2 * int'(REF_HALF)));
    endtask : t_pll

    task t_power_down;
        cyc(1);
        power_on <= 1'b0;
        cyc(10);
        @(negedge clk);
        check(16'(init_state), 16'(settle_wait_state));
        check(16'({charge_pump_en, sys_activity_en}), 16'h0000);
        check(16'({power_good, board_ready}), 16'h0000);
    endtask : t_power_down

    // Main sequence.
    initial begin
        errors      = 0;
        check_count = 0;
        rst         = 1'b1;
        power_on    = 1'b0;
        bypass_req  = 1'b1;
        strap_cfg   = 6'h00;
        irq_src     = 6'h00;
        cyc(5);
        rst <= 1'b0;
        t_reset();
        t_divisors();
        t_frame();
        t_irq();
        t_pll();
        t_power_down();
        wrap_up();
    end
endmodule : strap_config_clock_ratio_tb
